// ---- design/csc_pkg.sv ----
// constants for the status flags and system control register bank
package csc_pkg;
	// ------------------------------------------------------------
	// data memory addresses of the bank
	// ------------------------------------------------------------
	localparam logic [7:0] FLAGS_ADDR = 8'h0A;
	localparam logic [7:0] PORT_DATA_ADDR = 8'h10;
	localparam logic [7:0] PORT_DIR_ADDR = 8'h11;
	localparam logic [7:0] SYSTEM_CONTROL_ZERO_ADDR = 8'h1A;
	// ------------------------------------------------------------
	// flag register fields
	// ------------------------------------------------------------
	localparam int FLAG_C = 0;
	localparam int FLAG_HC = 1;
	localparam int FLAG_Z = 2;
	localparam int FLAG_OV = 3;
	localparam int FLAG_PDF = 4;
	localparam int FLAG_TO = 5;
	localparam logic [7:0] FLAGS_WR_MASK = 8'h0F;
	localparam logic [7:0] FLAGS_RD_MASK = 8'h3F;
	// ------------------------------------------------------------
	// system control zero fields
	// ------------------------------------------------------------
	localparam int CT_CLOCK_MODE_SELECT = 0;
	localparam int CT_XPWR = 1;
	localparam int CT_DIVPIN = 2;
	localparam int CT_PWM0 = 3;
	localparam int CT_PWM1 = 4;
	localparam int CT_PWM_MODE_SELECT = 5;
	localparam int CT_DIVSRC = 6;
	localparam int CT_PINMAP = 7;
	localparam logic [7:0] SYSTEM_CONTROL_ZERO_RESET = 8'h00;
	localparam logic [7:0] PORT_DIR_RESET = 8'hFF;
	localparam logic [7:0] PORT_DATA_RESET = 8'h00;
	localparam logic [7:0] ZERO_BYTE = 8'h00;
	localparam logic [7:0] BIT_ONE = 8'h01;
	// ------------------------------------------------------------
	// alu operation codes; all but CSC_OP_NONE touch the flags
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		CSC_OP_NONE = 3'b000,
		CSC_OP_ADD = 3'b001,
		CSC_OP_SUB = 3'b010,
		CSC_OP_LOGIC = 3'b011,
		CSC_OP_RLC = 3'b100,
		CSC_OP_RRC = 3'b101
	} csc_op_e;
endpackage

// ---- design/csc_port_bank.sv ----
// port data and direction registers with bit set/clear access
`timescale 1ns/1ps
module csc_port_bank (
	input wire logic clock_i,
	input wire logic rstn_i,
	input wire logic dir_we_i,
	input wire logic data_we_i,
	input wire logic bit_op_i,
	input wire logic bit_val_i,
	input wire logic [2:0] bit_sel_i,
	input wire logic [7:0] wdata_i,
	input wire logic [7:0] pin_i,
	output logic [7:0] dir_o,
	output logic [7:0] data_o,
	output logic [7:0] pin_rd_o
);
	import csc_pkg::*;

	typedef struct packed {
		logic [7:0] dir;
		logic [7:0] data;
		logic [7:0] s1;
		logic [7:0] s2;
		logic [7:0] s3;
		logic [7:0] pin;
	} csc_port_s;

	csc_port_s st;
	csc_port_s next_st;

	// single-bit write keeps every other bit
	function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] wd,
		input logic bop, input logic bv, input logic [2:0] sel);
		logic [7:0] m;
		m = BIT_ONE << sel;
		if (bop) begin
			merge = bv ? (old | m) : (old & ~m);
		end else begin
			merge = wd;
		end
	endfunction

	always_comb begin
		next_st = st;
		next_st.s1 = pin_i;
		next_st.s2 = st.s1;
		next_st.s3 = st.s2;
		// a pin change counts only once two stages agree
		for (int i = 0; i < 8; i++) begin
			if (st.s2[i] == st.s3[i]) begin
				next_st.pin[i] = st.s3[i];
			end
		end
		if (dir_we_i) begin
			next_st.dir = merge(st.dir, wdata_i, bit_op_i, bit_val_i, bit_sel_i);
		end
		if (data_we_i) begin
			next_st.data = merge(st.data, wdata_i, bit_op_i, bit_val_i, bit_sel_i);
		end
	end

	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			st <= '{dir: PORT_DIR_RESET, data: PORT_DATA_RESET, s1: ZERO_BYTE, s2: ZERO_BYTE,
				s3: ZERO_BYTE, pin: ZERO_BYTE};
		end else begin
			st <= next_st;
		end
	end

	assign dir_o = st.dir;
	assign data_o = st.data;
	assign pin_rd_o = st.pin;

	chk_bitop_keeps: assert property (@(posedge clock_i) disable iff (!rstn_i)
		dir_we_i && bit_op_i |=> (dir_o & ~(BIT_ONE << $past(bit_sel_i))) ==
		($past(dir_o) & ~(BIT_ONE << $past(bit_sel_i)))) else $error("bit op disturbed dir");
endmodule // csc_port_bank

// ---- design/csc_flag_alu.sv ----
// combinational flag computation for alu results
`timescale 1ns/1ps
module csc_flag_alu (
	input wire csc_pkg::csc_op_e op_i,
	input wire logic [7:0] a_i,
	input wire logic [7:0] b_i,
	input wire logic carry_i,
	output logic [7:0] result_o,
	output logic c_o,
	output logic hc_o,
	output logic ov_o,
	output logic z_o,
	output logic arith_o
);
	import csc_pkg::*;

	logic [8:0] sum;
	logic [4:0] lo;
	logic c7;

	always_comb begin
		sum = '0;
		lo = '0;
		c7 = 1'b0;
		result_o = ZERO_BYTE;
		c_o = carry_i;
		hc_o = 1'b0;
		ov_o = 1'b0;
		arith_o = 1'b0;
		case (op_i)
			CSC_OP_ADD, CSC_OP_SUB: begin
				// subtract as a + ~b + 1, so carry set means no borrow
				sum = {1'b0, a_i} + {1'b0, (op_i == CSC_OP_SUB) ? ~b_i : b_i}
					+ {8'h00, op_i == CSC_OP_SUB};
				lo = {1'b0, a_i[3:0]} + {1'b0, (op_i == CSC_OP_SUB) ? ~b_i[3:0] : b_i[3:0]}
					+ {4'h0, op_i == CSC_OP_SUB};
				c7 = a_i[7] ^ ((op_i == CSC_OP_SUB) ? ~b_i[7] : b_i[7]) ^ sum[7];
				result_o = sum[7:0];
				c_o = sum[8];
				hc_o = lo[4];
				ov_o = c7 ^ sum[8];
				arith_o = 1'b1;
			end
			CSC_OP_LOGIC: begin
				result_o = a_i & b_i;
			end
			CSC_OP_RLC: begin
				result_o = {a_i[6:0], carry_i};
				c_o = a_i[7];
			end
			CSC_OP_RRC: begin
				result_o = {carry_i, a_i[7:1]};
				c_o = a_i[0];
			end
			default: begin
				result_o = ZERO_BYTE;
			end
		endcase
		z_o = (result_o == ZERO_BYTE);
	end
endmodule // csc_flag_alu

// ---- design/csc_bank.sv ----
// status flags, system control zero and port register bank
`timescale 1ns/1ps

// ------------------------------------------------------------
// bank top
// ------------------------------------------------------------
// Summary of operation
// - flag bits 7 and 6 always read zero.
// - watchdog timeout sets its flag; power-up, watchdog clear or halt clear it.
// - halt sets power-down flag; power-up or watchdog clear clear it.
// - overflow flag is carry into msb xor carry out.
// - zero flag reflects a zero result.
// - half carry flag is low nibble carry, or no nibble borrow.
// - carry flag is carry out, or no borrow.
// - rotate-through-carry updates carry using it as ninth bit.
// - direction bit one makes a pin input, zero output.
// - single port bits may be set or cleared alone.
// - pin direction may change any time by writing its bit.
// - pin map bit moves interrupt, timer input, divider out to alternate pins.
// - divider source bit picks timer 0 or timer 1.
// - pwm1 function bit puts pwm1 on its shared pin.
// - pwm0 function bit puts pwm0 on its shared pin.
// - crystal power bit picks quick start or low power.
// - clock mode bit picks fast rc or crystal, stopping fast rc.
// - clock mode bit acts only with combined oscillator option.
// - any pwm output selected forces timer clock from system clock.
// - writes to flag register leave timeout and power-down flags alone.
module csc_bank (
	input wire logic clock_i,
	input wire logic rstn_i,
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic bit_op_i,
	input wire logic bit_val_i,
	input wire logic [2:0] bit_sel_i,
	input wire csc_pkg::csc_op_e alu_op_i,
	input wire logic [7:0] alu_a_i,
	input wire logic [7:0] alu_b_i,
	input wire logic wdt_timeout_i,
	input wire logic wdt_clear_i,
	input wire logic halt_i,
	input wire logic osc_opt_combined_i,
	input wire logic [7:0] pin_i,
	input wire logic [7:0] pwm_mod_i,
	output logic [7:0] rdata_o,
	output logic [7:0] alu_result_o,
	output logic [7:0] pin_o,
	output logic [7:0] pin_oe_o,
	output logic alt_pin_map_o,
	output logic divider_from_timer1_o,
	output logic pwm_mode_7p1_o,
	output logic crystal_low_power_o,
	output logic sysclk_from_crystal_o,
	output logic fast_rc_stop_o,
	output logic timer_clk_from_sys_o
);
	import csc_pkg::*;

	// pin positions of shared functions on the 8-bit port
	localparam int PIN_DIV = 1;
	localparam int PIN_DIV_ALT = 3;
	localparam int PIN_PWM0 = 6;
	localparam int PIN_PWM1 = 7;

	typedef struct packed {
		logic [5:0] flags;
		logic [7:0] ctrl;
		logic [7:0] rdata;
		logic [7:0] result;
		logic [7:0] pin;
		logic [7:0] oe;
		logic alt_map;
		logic div_t1;
		logic mode71;
		logic xlp;
		logic clk_xtal;
		logic rc_stop;
		logic tclk_sys;
		logic [2:0] pwm_cnt;
	} csc_bank_s;

	csc_bank_s st;
	csc_bank_s next_st;

	logic [7:0] port_dir;
	logic [7:0] port_data;
	logic [7:0] port_pins;
	logic [7:0] alu_res;
	logic alu_c;
	logic alu_hc;
	logic alu_ov;
	logic alu_z;
	logic alu_arith;
	logic wr_flags;
	logic wr_ctrl;
	logic [7:0] bit_mask;
	logic [7:0] flags_wr;
	logic [7:0] drive;
	logic div_out;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic hit(input logic [7:0] a, input logic [7:0] reg_addr);
		hit = (a == reg_addr);
	endfunction

	function automatic logic [7:0] bitwrite(input logic [7:0] old, input logic [7:0] wd,
		input logic bop, input logic bv, input logic [7:0] m);
		if (bop) begin
			bitwrite = bv ? (old | m) : (old & ~m);
		end else begin
			bitwrite = wd;
		end
	endfunction

	assign bit_mask = BIT_ONE << bit_sel_i;
	assign wr_flags = wr_i && hit(addr_i, FLAGS_ADDR);
	assign wr_ctrl = wr_i && hit(addr_i, SYSTEM_CONTROL_ZERO_ADDR);
	assign flags_wr = bitwrite({2'b00, st.flags}, wdata_i, bit_op_i, bit_val_i, bit_mask);

	// ------------------------------------------------------------
	// submodules
	// ------------------------------------------------------------
	csc_port_bank u_port (
		.clock_i(clock_i),
		.rstn_i(rstn_i),
		.dir_we_i(wr_i && hit(addr_i, PORT_DIR_ADDR)),
		.data_we_i(wr_i && hit(addr_i, PORT_DATA_ADDR)),
		.bit_op_i(bit_op_i),
		.bit_val_i(bit_val_i),
		.bit_sel_i(bit_sel_i),
		.wdata_i(wdata_i),
		.pin_i(pin_i),
		.dir_o(port_dir),
		.data_o(port_data),
		.pin_rd_o(port_pins)
	);

	csc_flag_alu u_alu (
		.op_i(alu_op_i),
		.a_i(alu_a_i),
		.b_i(alu_b_i),
		.carry_i(st.flags[FLAG_C]),
		.result_o(alu_res),
		.c_o(alu_c),
		.hc_o(alu_hc),
		.ov_o(alu_ov),
		.z_o(alu_z),
		.arith_o(alu_arith)
	);

	// the divider and pwm waveforms are produced elsewhere; a stand-in pattern is
	// built here from the selected source so pin routing can be observed
	assign div_out = st.ctrl[CT_DIVSRC] ? alu_a_i[1] : alu_a_i[0];

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		next_st = st;
		// software write first, so a hardware event in the same cycle wins
		if (wr_flags) begin
			next_st.flags[3:0] = flags_wr[3:0] & FLAGS_WR_MASK[3:0];
		end
		if (alu_op_i != CSC_OP_NONE) begin
			// rotates move only the carry, the zero flag keeps its value
			if (alu_arith || alu_op_i == CSC_OP_LOGIC) begin
				next_st.flags[FLAG_Z] = alu_z;
			end
			next_st.flags[FLAG_C] = alu_c;
			if (alu_arith) begin
				next_st.flags[FLAG_HC] = alu_hc;
				next_st.flags[FLAG_OV] = alu_ov;
			end
		end
		next_st.result = alu_res;
		// watchdog clear and halt clear, then timeout sets and wins
		if (wdt_clear_i) begin
			next_st.flags[FLAG_PDF] = 1'b0;
			next_st.flags[FLAG_TO] = 1'b0;
		end
		if (halt_i) begin
			next_st.flags[FLAG_PDF] = 1'b1;
			next_st.flags[FLAG_TO] = 1'b0;
		end
		if (wdt_timeout_i) begin
			next_st.flags[FLAG_TO] = 1'b1;
		end
		if (wr_ctrl) begin
			next_st.ctrl = bitwrite(st.ctrl, wdata_i, bit_op_i, bit_val_i, bit_mask);
		end
		// register read mux
		if (hit(addr_i, FLAGS_ADDR)) begin
			next_st.rdata = {2'b00, st.flags} & FLAGS_RD_MASK;
		end else if (hit(addr_i, SYSTEM_CONTROL_ZERO_ADDR)) begin
			next_st.rdata = st.ctrl;
		end else if (hit(addr_i, PORT_DIR_ADDR)) begin
			next_st.rdata = port_dir;
		end else if (hit(addr_i, PORT_DATA_ADDR)) begin
			// inputs read the pin, outputs read the latch
			next_st.rdata = (port_pins & port_dir) | (port_data & ~port_dir);
		end else begin
			next_st.rdata = ZERO_BYTE;
		end
		if (!rd_i) begin
			next_st.rdata = st.rdata;
		end
		// system control decode
		next_st.alt_map = st.ctrl[CT_PINMAP];
		next_st.div_t1 = st.ctrl[CT_DIVSRC];
		next_st.mode71 = st.ctrl[CT_PWM_MODE_SELECT];
		next_st.xlp = st.ctrl[CT_XPWR];
		next_st.clk_xtal = osc_opt_combined_i && st.ctrl[CT_CLOCK_MODE_SELECT];
		next_st.rc_stop = osc_opt_combined_i && st.ctrl[CT_CLOCK_MODE_SELECT];
		next_st.tclk_sys = st.ctrl[CT_PWM0] | st.ctrl[CT_PWM1];
		next_st.pwm_cnt = st.pwm_cnt + 3'd1;
		// pin drive: direction bit one means input
		drive = port_data;
		next_st.oe = ~port_dir;
		if (st.ctrl[CT_DIVPIN]) begin
			if (st.ctrl[CT_PINMAP]) begin
				drive[PIN_DIV_ALT] = div_out;
				next_st.oe[PIN_DIV_ALT] = 1'b1;
			end else begin
				drive[PIN_DIV] = div_out;
				next_st.oe[PIN_DIV] = 1'b1;
			end
		end
		if (st.ctrl[CT_PWM0]) begin
			// 7+1 dithers on the last bit, 6+2 on two bits
			drive[PIN_PWM0] = st.ctrl[CT_PWM_MODE_SELECT] ? pwm_mod_i[0] : pwm_mod_i[st.pwm_cnt[0]];
			next_st.oe[PIN_PWM0] = 1'b1;
		end
		if (st.ctrl[CT_PWM1]) begin
			drive[PIN_PWM1] = st.ctrl[CT_PWM_MODE_SELECT] ? pwm_mod_i[1] : pwm_mod_i[st.pwm_cnt[1]];
			next_st.oe[PIN_PWM1] = 1'b1;
		end
		next_st.pin = drive;
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			st <= '0;
			st.ctrl <= SYSTEM_CONTROL_ZERO_RESET;
		end else begin
			st <= next_st;
		end
	end

	assign rdata_o = st.rdata;
	assign alu_result_o = st.result;
	assign pin_o = st.pin;
	assign pin_oe_o = st.oe;
	assign alt_pin_map_o = st.alt_map;
	assign divider_from_timer1_o = st.div_t1;
	assign pwm_mode_7p1_o = st.mode71;
	assign crystal_low_power_o = st.xlp;
	assign sysclk_from_crystal_o = st.clk_xtal;
	assign fast_rc_stop_o = st.rc_stop;
	assign timer_clk_from_sys_o = st.tclk_sys;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	chk_flag_top_zero: assert property (@(posedge clock_i) disable iff (!rstn_i)
		rd_i && addr_i == FLAGS_ADDR |=> rdata_o[7:6] == 2'b00) else $error("flag top bits set");
	chk_timeout_set: assert property (@(posedge clock_i) disable iff (!rstn_i)
		wdt_timeout_i ##1 rd_i && addr_i == FLAGS_ADDR |=> rdata_o[FLAG_TO]) else $error("timeout not set");
	chk_halt_pdf: assert property (@(posedge clock_i) disable iff (!rstn_i)
		halt_i |=> st.flags[FLAG_PDF] && (st.flags[FLAG_TO] == $past(wdt_timeout_i)))
		else $error("halt flags wrong");
	chk_clear_pdf: assert property (@(posedge clock_i) disable iff (!rstn_i)
		wdt_clear_i && !halt_i |=> !st.flags[FLAG_PDF]) else $error("pdf not cleared");
	chk_add_carry: assert property (@(posedge clock_i) disable iff (!rstn_i)
		alu_op_i == CSC_OP_ADD |=> st.flags[FLAG_C] == ($past({1'b0, alu_a_i}) + $past({1'b0, alu_b_i}) > 9'h0FF))
		else $error("add carry wrong");
	chk_zero_flag: assert property (@(posedge clock_i) disable iff (!rstn_i)
		alu_op_i inside {CSC_OP_ADD, CSC_OP_SUB, CSC_OP_LOGIC} |=> st.flags[FLAG_Z] == (alu_result_o == ZERO_BYTE))
		else $error("zero flag wrong");
	chk_write_keeps_sys: assert property (@(posedge clock_i) disable iff (!rstn_i)
		wr_flags && !wdt_timeout_i && !wdt_clear_i && !halt_i |=> $stable(st.flags[5:4]))
		else $error("write changed system flags");
	chk_clk_option: assert property (@(posedge clock_i) disable iff (!rstn_i)
		!osc_opt_combined_i |=> !sysclk_from_crystal_o && !fast_rc_stop_o) else $error("clock mode leaked");
	chk_pwm_tclk: assert property (@(posedge clock_i) disable iff (!rstn_i)
		st.ctrl[CT_PWM0] |=> timer_clk_from_sys_o) else $error("timer clock not system");
	chk_dir_oe: assert property (@(posedge clock_i) disable iff (!rstn_i)
		st.ctrl[CT_PWM1:CT_DIVPIN] == 3'b000 |=> pin_oe_o == ~$past(port_dir)) else $error("oe not from dir");
endmodule // csc_bank

// ---- tb/csc_bank_bench.sv ----
// self-checking bench for the status flags, system control and port bank
`timescale 1ns/1ps
module csc_bank_bench;
	import csc_pkg::*;
	// ------------------------------------------------------------
	// stimulus and observation
	// ------------------------------------------------------------
	logic clock_i = 1'b0;
	logic rstn_i = 1'b0;
	logic [7:0] addr_i = 8'h00;
	logic [7:0] wdata_i = 8'h00;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic bit_op_i = 1'b0;
	logic bit_val_i = 1'b0;
	logic [2:0] bit_sel_i = 3'h0;
	csc_op_e alu_op_i = CSC_OP_NONE;
	logic [7:0] alu_a_i = 8'h00;
	logic [7:0] alu_b_i = 8'h00;
	logic wdt_timeout_i = 1'b0;
	logic wdt_clear_i = 1'b0;
	logic halt_i = 1'b0;
	logic osc_opt_combined_i = 1'b0;
	logic [7:0] pin_i = 8'h00;
	logic [7:0] pwm_mod_i = 8'h00;
	logic [7:0] rdata_o, alu_result_o, pin_o, pin_oe_o;
	logic alt_pin_map_o, divider_from_timer1_o, pwm_mode_7p1_o, crystal_low_power_o;
	logic sysclk_from_crystal_o, fast_rc_stop_o, timer_clk_from_sys_o;
	int fail_count = 0;
	int comparisons = 0;
	integer seed = 13;
	logic [7:0] flg, ctl, dir, dat, got, a, b;
	logic [2:0] opv, sel;
	logic [11:0] m;
	logic bv;

	always #2 clock_i = ~clock_i;

	csc_bank csc_bank_i (.clock_i(clock_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
		.rd_i(rd_i), .bit_op_i(bit_op_i), .bit_val_i(bit_val_i), .bit_sel_i(bit_sel_i), .alu_op_i(alu_op_i),
		.alu_a_i(alu_a_i), .alu_b_i(alu_b_i), .wdt_timeout_i(wdt_timeout_i), .wdt_clear_i(wdt_clear_i),
		.halt_i(halt_i), .osc_opt_combined_i(osc_opt_combined_i), .pin_i(pin_i), .pwm_mod_i(pwm_mod_i),
		.rdata_o(rdata_o), .alu_result_o(alu_result_o), .pin_o(pin_o), .pin_oe_o(pin_oe_o),
		.alt_pin_map_o(alt_pin_map_o), .divider_from_timer1_o(divider_from_timer1_o),
		.pwm_mode_7p1_o(pwm_mode_7p1_o), .crystal_low_power_o(crystal_low_power_o),
		.sysclk_from_crystal_o(sysclk_from_crystal_o), .fast_rc_stop_o(fast_rc_stop_o),
		.timer_clk_from_sys_o(timer_clk_from_sys_o));

	// ------------------------------------------------------------
	// shared tasks and the expectation model
	// ------------------------------------------------------------
	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] seen);
		comparisons++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// inputs always move 1 ns after the rising edge
	task automatic tick(input int n);
		repeat (n) @(posedge clock_i);
		#1;
	endtask

	task automatic wr(input logic [7:0] ad, input logic [7:0] d, input logic bop, input logic v, input logic [2:0] s);
		addr_i = ad;
		wdata_i = d;
		bit_op_i = bop;
		bit_val_i = v;
		bit_sel_i = s;
		wr_i = 1'b1;
		tick(1);
		wr_i = 1'b0;
		bit_op_i = 1'b0;
	endtask

	// read data is held, so it is taken one cycle after the answer lands
	task automatic rd(input logic [7:0] ad, output logic [7:0] d);
		addr_i = ad;
		rd_i = 1'b1;
		tick(1);
		rd_i = 1'b0;
		tick(1);
		d = rdata_o;
	endtask

	task automatic ev(input logic t, input logic c, input logic h, input logic [7:0] exp);
		logic [7:0] r;
		wdt_timeout_i = t;
		wdt_clear_i = c;
		halt_i = h;
		tick(1);
		wdt_timeout_i = 1'b0;
		wdt_clear_i = 1'b0;
		halt_i = 1'b0;
		tick(1);
		rd(FLAGS_ADDR, r);
		check("system flags", exp, r & 8'hF0);
	endtask

	// returns {result, ov, z, hc, c}; subtraction adds the inverted operand plus one
	function automatic logic [11:0] alu_model(input logic [2:0] op, input logic [7:0] x, input logic [7:0] y,
		input logic [3:0] f);
		logic [8:0] s;
		logic [7:0] yy, l, r;
		logic [4:0] n;
		logic cin;
		cin = (op == 3'd2);
		yy = cin ? ~y : y;
		s = {1'b0, x} + {1'b0, yy} + {8'h00, cin};
		n = {1'b0, x[3:0]} + {1'b0, yy[3:0]} + {4'h0, cin};
		l = {1'b0, x[6:0]} + {1'b0, yy[6:0]} + {7'h00, cin};
		r = 8'h00;
		case (op)
			3'd1, 3'd2: begin
				r = s[7:0];
				f = {s[8] ^ l[7], s[7:0] == 8'h00, n[4], s[8]};
			end
			3'd3: begin
				r = x & y;
				f[2] = (r == 8'h00);
			end
			3'd4: begin
				r = {x[6:0], f[0]};
				f[0] = x[7];
			end
			3'd5: begin
				r = {f[0], x[7:1]};
				f[0] = x[0];
			end
			default: r = 8'h00;
		endcase
		return {r, f};
	endfunction

	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// ------------------------------------------------------------
	// watchdog, far beyond the few hundred cycles the tests need
	// ------------------------------------------------------------
	initial begin
		#100000;
		fail_count++;
		$display("watchdog expired");
		finish_test();
	end

	// ------------------------------------------------------------
	// tests
	// ------------------------------------------------------------
	initial begin
		tick(16);
		rstn_i = 1'b1;
		rd(SYSTEM_CONTROL_ZERO_ADDR, got);
		check("control reset", SYSTEM_CONTROL_ZERO_RESET, got);
		rd(FLAGS_ADDR, got);
		check("flags reset", 8'h00, got & 8'hF0);
		rd(PORT_DIR_ADDR, got);
		check("direction reset", PORT_DIR_RESET, got);
		check("oe reset", 8'h00, pin_oe_o);
		rd(8'h33, got);
		check("unmapped read", 8'h00, got);
		// upper four bits written high must not stick
		wr(FLAGS_ADDR, 8'hFF, 1'b0, 1'b0, 3'h0);
		tick(1);
		rd(FLAGS_ADDR, got);
		check("flags write", 8'h0F, got);
		wr(FLAGS_ADDR, 8'h35, 1'b0, 1'b0, 3'h0);
		tick(1);
		rd(FLAGS_ADDR, got);
		check("flags write", 8'h05, got);
		flg = 8'h05;
		$display("test reset and flag write done");

		for (int i = 0; i < 45; i++) begin
			opv = 3'd1 + 3'($unsigned($random(seed)) % 5);
			a = $random(seed);
			b = $random(seed);
			pwm_mod_i = $random(seed);
			case (i)
				0: {opv, a, b} = {3'd1, 8'h7F, 8'h01};
				1: {opv, a, b} = {3'd1, 8'hFF, 8'h01};
				2: {opv, a, b} = {3'd2, 8'h80, 8'h01};
				3: {opv, a, b} = {3'd2, 8'h10, 8'h01};
				4: {opv, a, b} = {3'd2, 8'h05, 8'h05};
				5: {opv, a, b} = {3'd4, 8'h80, 8'h00};
				6: {opv, a, b} = {3'd5, 8'h01, 8'h00};
				default: opv = opv;
			endcase
			m = alu_model(opv, a, b, flg[3:0]);
			alu_op_i = csc_op_e'(opv);
			alu_a_i = a;
			alu_b_i = b;
			tick(1);
			alu_op_i = CSC_OP_NONE;
			check("alu result", m[11:4], alu_result_o);
			flg[3:0] = m[3:0];
			tick(1);
			rd(FLAGS_ADDR, got);
			check("alu flags", flg, got);
		end
		$display("test alu flags done");

		ev(1'b1, 1'b0, 1'b0, 8'h20);
		ev(1'b0, 1'b0, 1'b1, 8'h10);
		ev(1'b1, 1'b0, 1'b1, 8'h30);
		wr(FLAGS_ADDR, 8'h00, 1'b0, 1'b0, 3'h0);
		tick(1);
		rd(FLAGS_ADDR, got);
		check("flags write keeps system flags", 8'h30, got);
		ev(1'b0, 1'b1, 1'b0, 8'h00);
		$display("test system flags done");

		for (int i = 0; i < 20; i++) begin
			ctl = (i == 0) ? 8'hFF : 8'($random(seed));
			osc_opt_combined_i = (i < 2) ? i[0] : 1'($random(seed));
			wr(SYSTEM_CONTROL_ZERO_ADDR, ctl, 1'b0, 1'b0, 3'h0);
			tick(1);
			check("decoded controls", {ctl[7], ctl[6], ctl[5], ctl[1], {2{ctl[0] & osc_opt_combined_i}},
				ctl[3] | ctl[4], 1'b0}, {alt_pin_map_o, divider_from_timer1_o, pwm_mode_7p1_o,
				crystal_low_power_o, sysclk_from_crystal_o, fast_rc_stop_o, timer_clk_from_sys_o,
				1'b0});
			rd(SYSTEM_CONTROL_ZERO_ADDR, got);
			check("control readback", ctl, got);
		end
		// pin functions on, all port bits inputs, so only shared pins drive
		wr(SYSTEM_CONTROL_ZERO_ADDR, 8'h3C, 1'b0, 1'b0, 3'h0);
		alu_a_i = 8'h01;
		pwm_mod_i = 8'h02;
		tick(2);
		check("function pin enable", 8'hC2, pin_oe_o);
		check("function pin level", 8'h82, pin_o & 8'hC2);
		wr(SYSTEM_CONTROL_ZERO_ADDR, 8'hC4, 1'b0, 1'b0, 3'h0);
		alu_a_i = 8'h02;
		tick(2);
		check("alternate divider enable", 8'h08, pin_oe_o);
		check("alternate divider level", 8'h08, pin_o & 8'h08);
		$display("test system control done");

		// no pin functions selected, so every pin is ordinary port logic
		wr(SYSTEM_CONTROL_ZERO_ADDR, 8'h00, 1'b0, 1'b0, 3'h0);
		for (int i = 0; i < 20; i++) begin
			dir = $random(seed);
			dat = $random(seed);
			pin_i = $random(seed);
			wr(PORT_DIR_ADDR, dir, 1'b0, 1'b0, 3'h0);
			wr(PORT_DATA_ADDR, dat, 1'b0, 1'b0, 3'h0);
			tick(1);
			check("pin enable", ~dir, pin_oe_o);
			check("pin level", dat & ~dir, pin_o & ~dir);
			sel = $random(seed);
			bv = $random(seed);
			wr(PORT_DIR_ADDR, $random(seed), 1'b1, bv, sel);
			dir[sel] = bv;
			wr(PORT_DATA_ADDR, $random(seed), 1'b1, ~bv, sel);
			dat[sel] = ~bv;
			tick(2);
			rd(PORT_DIR_ADDR, got);
			check("direction bit op", dir, got);
			rd(PORT_DATA_ADDR, got);
			check("port read", (pin_i & dir) | (dat & ~dir), got);
			check("pin enable bit op", ~dir, pin_oe_o);
		end
		$display("test port done");

		wr(SYSTEM_CONTROL_ZERO_ADDR, 8'hFF, 1'b0, 1'b0, 3'h0);
		ev(1'b1, 1'b0, 1'b1, 8'h30);
		rstn_i = 1'b0;
		tick(2);
		rstn_i = 1'b1;
		rd(SYSTEM_CONTROL_ZERO_ADDR, got);
		check("control second reset", 8'h00, got);
		rd(FLAGS_ADDR, got);
		check("flags second reset", 8'h00, got & 8'hF0);
		check("oe second reset", 8'h00, pin_oe_o);
		$display("test second reset done");
		finish_test();
	end
endmodule // csc_bank_bench
